// ===== apg_dec_model.sv
// Purpose: Decoder-side model that presents operand requests to the generator
// Assumes: Caller picks distinct pointers for two modifying operands
// Notes: Each send waits for a rising edge, then drives by non-blocking assignment
module apg_dec_model (
  input wire logic mclk, // Clock
  output logic op_valid, // Request
  output logic op_pair, // Two operands
  output logic [2:0] sel_ptr_x, // First pointer
  output apg_pkg::apg_mode_e mode_x, // First form
  output logic wide_x, // First width
  output logic [2:0] sel_ptr_y, // Second pointer
  output apg_pkg::apg_mode_e mode_y, // Second form
  output logic wide_y, // Second width
  output logic [15:0] long_offset_const, // Extension word
  output logic [2:0] short_offset_const // Short offset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quiet request lines at time zero
  initial begin
    {op_valid, op_pair, sel_ptr_x, wide_x, sel_ptr_y, wide_y} = '0;
    mode_x = apg_pkg::OM_PLAIN;
    mode_y = apg_pkg::OM_PLAIN;
    {long_offset_const, short_offset_const} = {16'h0000, 3'h1};
  end
  // One request per call, taken at the following edge
  task automatic send(bit v, bit pr, logic [2:0] px, apg_pkg::apg_mode_e mx, bit wx,
      logic [2:0] py, apg_pkg::apg_mode_e my, bit wy, logic [15:0] k16, logic [2:0] k3);
    @(posedge mclk);
    op_valid <= v;
    op_pair <= pr;
    sel_ptr_x <= px;
    mode_x <= mx;
    wide_x <= wx;
    sel_ptr_y <= py;
    mode_y <= my;
    wide_y <= wy;
    long_offset_const <= k16;
    short_offset_const <= k3;
  endtask : send
endmodule : apg_dec_model

// ===== apg_pkg.sv
// Purpose: Shared constants and types for the pointer address generator
// Assumes: 32-bit Avalon-MM register bus, word aligned offsets
// Notes: Offsets are byte addresses; fields sit in the low bits
package apg_pkg;
  // Widths
  localparam int unsigned ADDR_W = 23; // Data-memory address width
  localparam int unsigned LOW_W = 16; // Pointer low part width
  localparam int unsigned NPTR = 8; // Number of aux pointers
  // Register byte offsets
  localparam logic [7:0] OFS_PTR0 = 8'h00; // aux_pointer 0..7 at 0x00..0x1c
  localparam logic [7:0] OFS_TIDX0 = 8'h20; // temp_index_zero
  localparam logic [7:0] OFS_TIDX1 = 8'h24; // temp_index_one
  localparam logic [7:0] OFS_BASE0 = 8'h28; // circ_buffer_base 0..3 at 0x28..0x34
  localparam logic [7:0] OFS_STAT2 = 8'h38; // status_word_two
  localparam logic [7:0] OFS_EVT = 8'h3c; // Event counters, read only
  // status_word_two fields
  localparam int unsigned ST_CIRC_LSB = 0; // circular_select_bit 0..7
  localparam int unsigned ST_PMS_BIT = 8; // pointer_mode_select
  localparam int unsigned ST_LCM_BIT = 9; // legacy_compat_mode
  localparam logic [9:0] ST_RESET = 10'h000; // Linear, DSP set, native index
  // Post steps
  localparam logic [22:0] STEP_NARROW = 23'h000001; // 16-bit or 1-bit access
  localparam logic [22:0] STEP_WIDE = 23'h000002; // 32-bit or 2-bit access
  // Operand forms
  typedef enum logic [3:0] {
    OM_PLAIN, OM_POST_INC, OM_POST_DEC, OM_PRE_INC, OM_PRE_DEC,
    OM_POST_ADD_IDX, OM_POST_SUB_IDX, OM_BASE_IDX,
    OM_BASE_T1, OM_POST_ADD_T1, OM_POST_SUB_T1,
    OM_BREV_ADD, OM_BREV_SUB, OM_BASE_K16, OM_PRE_ADD_K16, OM_BASE_K3
  } apg_mode_e;
endpackage : apg_pkg

// ===== apg_top.sv
// Purpose: Aux pointer indirect address generator with register file
// Assumes: Decoder presents one request per cycle on op_valid
// Notes: Addresses and pointer updates register on the same edge
// Operation
// (R1) Bit-reverse subtract index after address issue
// (R2) Circular bit-reverse adds base, pointer unchanged
// (R3) Long-constant base form keeps pointer
// (R4) Long-constant operands never issue in parallel
// (R5) Pre-add long constant writes pointer, then addresses
// (R6) Post step is one or two
// (R7) Compat bit selects zero pointer or temp index
// (R8) Base plus index keeps pointer
// (R9) Control short offset one to seven
// (R10) Dual mode issues two 23-bit addresses
// (R11) Each dual pointer modified per own configuration
// (R12) First parallel operand is first dual slot
// (R13) Dual set ignores mode select, limited forms
// (R14) Dual temp-one forms ignore compat bit
// (R15) Dual post step one or two
// (R16) Software avoids double modification of shared pointer
// (R17) Pointer arithmetic modulo 8M, page updates
// (R18) Base added only when circular
// (R19) Mode select picks operand list
// (R20) Pointer low half, page high seven bits
// (R21) Per-pointer circular select bit
// (R22) Pointer update written with address issue
module apg_top (
  input wire logic mclk, // 125 MHz clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [7:0] avs_address, // Byte address
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic op_valid, // Decoder request
  input wire logic op_pair, // Two operands (dual or parallel pair)
  input wire logic [2:0] sel_ptr_x, // First slot pointer
  input wire apg_pkg::apg_mode_e mode_x, // First slot form
  input wire logic wide_x, // First slot 32-bit access
  input wire logic [2:0] sel_ptr_y, // Second slot pointer
  input wire apg_pkg::apg_mode_e mode_y, // Second slot form
  input wire logic wide_y, // Second slot 32-bit access
  input wire logic [15:0] long_offset_const, // Instruction extension
  input wire logic [2:0] short_offset_const, // Short offset
  output logic [22:0] addr_x, // First address
  output logic [22:0] addr_y, // Second address
  output logic addr_x_valid, // First address pulse
  output logic addr_y_valid, // Second address pulse
  output logic op_reject // Request refused pulse
);
  logic [22:0] ptr_q [8]; // aux_pointer with pointer_high_page
  logic [22:0] ptr_d [8];
  logic [15:0] tidx0_q, tidx0_d; // temp_index_zero
  logic [15:0] tidx1_q, tidx1_d; // temp_index_one
  logic [15:0] base_q [4]; // circ_buffer_base per pointer pair
  logic [15:0] base_d [4];
  logic [9:0] stat_q, stat_d; // status_word_two
  logic [15:0] nrej_q, nrej_d; // Refused request count
  logic [15:0] nok_q, nok_d; // Accepted request count
  logic [22:0] ax_q, ax_d, ay_q, ay_d; // Issued addresses
  logic vx_q, vx_d, vy_q, vy_d, rej_q, rej_d; // Output pulses
  logic [31:0] rd_q, rd_d; // Read data
  logic wait_q, wait_d; // Waitrequest
  logic pms, lcm; // Mode select and compat bits
  logic [15:0] idx_sel; // Index chosen by compat bit
  logic [22:0] ux_addr, uy_addr, ux_new, uy_new; // Unit results
  logic ux_wr, uy_wr; // Unit write enables
  logic ok_x, ok_y, accept; // Legality
  logic bus_wr; // Accepted write this cycle
  logic [31:0] wmask; // Byte lane mask

  assign pms = stat_q[apg_pkg::ST_PMS_BIT];
  assign lcm = stat_q[apg_pkg::ST_LCM_BIT];
  assign idx_sel = lcm ? ptr_q[0][15:0] : tidx0_q; // see (R7)

  // Legal single operand per selected list
  function automatic logic legal_single(input apg_pkg::apg_mode_e m, input logic ctl);
    logic r;
    r = 1'b1;
    if (ctl) begin // see (R19)
      r = !(m inside {apg_pkg::OM_PRE_INC, apg_pkg::OM_PRE_DEC, apg_pkg::OM_BASE_T1,
                      apg_pkg::OM_POST_ADD_T1, apg_pkg::OM_POST_SUB_T1,
                      apg_pkg::OM_BREV_ADD, apg_pkg::OM_BREV_SUB});
    end else begin
      r = (m != apg_pkg::OM_BASE_K3);
    end
    return r;
  endfunction : legal_single

  // Legal dual operand, independent of mode select
  function automatic logic legal_dual(input apg_pkg::apg_mode_e m);
    return m inside {apg_pkg::OM_PLAIN, apg_pkg::OM_POST_INC, apg_pkg::OM_POST_DEC,
                     apg_pkg::OM_POST_ADD_IDX, apg_pkg::OM_POST_SUB_IDX,
                     apg_pkg::OM_BASE_IDX, apg_pkg::OM_POST_ADD_T1,
                     apg_pkg::OM_POST_SUB_T1}; // see (R13)
  endfunction : legal_dual

  // First slot unit
  apg_unit u_x (
    .ptr(ptr_q[sel_ptr_x]),
    .mode(mode_x),
    .wide(wide_x),
    .idx(idx_sel),
    .tone(tidx1_q),
    .kconst(long_offset_const),
    .kshort(short_offset_const),
    .circ(stat_q[apg_pkg::ST_CIRC_LSB + sel_ptr_x]),
    .base(base_q[sel_ptr_x[2:1]]),
    .addr(ux_addr),
    .ptr_new(ux_new),
    .ptr_wr(ux_wr)
  );

  // Second slot unit, own circular configuration; see (R11)
  apg_unit u_y (
    .ptr(ptr_q[sel_ptr_y]),
    .mode(mode_y),
    .wide(wide_y),
    .idx(idx_sel),
    .tone(tidx1_q),
    .kconst(long_offset_const),
    .kshort(short_offset_const),
    .circ(stat_q[apg_pkg::ST_CIRC_LSB + sel_ptr_y]),
    .base(base_q[sel_ptr_y[2:1]]),
    .addr(uy_addr),
    .ptr_new(uy_new),
    .ptr_wr(uy_wr)
  );

  // Request legality and address issue
  always_comb begin
    if (op_pair) begin
      ok_x = legal_dual(mode_x); // Long constants fail here; see (R4)
      ok_y = legal_dual(mode_y);
    end else begin
      ok_x = legal_single(mode_x, pms);
      ok_y = 1'b1;
    end
    accept = op_valid && ok_x && ok_y;
    ax_d = accept ? ux_addr : ax_q; // see (R12)
    ay_d = (accept && op_pair) ? uy_addr : ay_q; // see (R10)
    vx_d = accept;
    vy_d = accept && op_pair;
    rej_d = op_valid && !accept;
    nok_d = accept ? 16'(nok_q + 16'h0001) : nok_q;
    nrej_d = rej_d ? 16'(nrej_q + 16'h0001) : nrej_q;
  end

  // Avalon slave: one wait cycle, answer on the next edge
  always_comb begin
    bus_wr = avs_write && wait_q;
    wait_d = !((avs_read || avs_write) && wait_q);
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{avs_byteenable[b]}};
    end
    rd_d = rd_q;
    if (avs_read && wait_q) begin
      rd_d = 32'h00000000; // Unmapped reads give zero
      if (avs_address < apg_pkg::OFS_TIDX0) begin
        rd_d = {9'h000, ptr_q[avs_address[4:2]]};
      end else if (avs_address == apg_pkg::OFS_TIDX0) begin
        rd_d = {16'h0000, tidx0_q};
      end else if (avs_address == apg_pkg::OFS_TIDX1) begin
        rd_d = {16'h0000, tidx1_q};
      end else if (avs_address >= apg_pkg::OFS_BASE0 && avs_address < apg_pkg::OFS_STAT2) begin
        rd_d = {16'h0000, base_q[2'(8'(avs_address - apg_pkg::OFS_BASE0) >> 2)]};
      end else if (avs_address == apg_pkg::OFS_STAT2) begin
        rd_d = {22'h000000, stat_q};
      end else if (avs_address == apg_pkg::OFS_EVT) begin
        rd_d = {nrej_q, nok_q};
      end
    end
  end

  // Register file next state; pointer update beats a bus write
  always_comb begin
    logic [31:0] old;
    old = '0;
    tidx0_d = tidx0_q;
    tidx1_d = tidx1_q;
    stat_d = stat_q;
    for (int i = 0; i < 8; i++) begin
      ptr_d[i] = ptr_q[i];
    end
    for (int i = 0; i < 4; i++) begin
      base_d[i] = base_q[i];
    end
    if (bus_wr && avs_address[1:0] == 2'b00) begin
      if (avs_address < apg_pkg::OFS_TIDX0) begin
        old = {9'h000, ptr_q[avs_address[4:2]]};
        ptr_d[avs_address[4:2]] = 23'((old & ~wmask) | (avs_writedata & wmask));
      end else if (avs_address == apg_pkg::OFS_TIDX0) begin
        old = {16'h0000, tidx0_q};
        tidx0_d = 16'((old & ~wmask) | (avs_writedata & wmask));
      end else if (avs_address == apg_pkg::OFS_TIDX1) begin
        old = {16'h0000, tidx1_q};
        tidx1_d = 16'((old & ~wmask) | (avs_writedata & wmask));
      end else if (avs_address >= apg_pkg::OFS_BASE0 && avs_address < apg_pkg::OFS_STAT2) begin
        old = {16'h0000, base_q[2'(8'(avs_address - apg_pkg::OFS_BASE0) >> 2)]};
        base_d[2'(8'(avs_address - apg_pkg::OFS_BASE0) >> 2)] =
          16'((old & ~wmask) | (avs_writedata & wmask));
      end else if (avs_address == apg_pkg::OFS_STAT2) begin
        old = {22'h000000, stat_q};
        stat_d = 10'((old & ~wmask) | (avs_writedata & wmask));
      end
    end
    // Second slot first so that first slot wins a shared pointer; see (R16)
    if (accept && op_pair && uy_wr) begin
      ptr_d[sel_ptr_y] = uy_new; // see (R11)
    end
    if (accept && ux_wr) begin
      ptr_d[sel_ptr_x] = ux_new; // see (R22)
    end
  end

  // State registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        ptr_q[i] <= '0;
      end
      for (int i = 0; i < 4; i++) begin
        base_q[i] <= '0;
      end
      tidx0_q <= '0;
      tidx1_q <= '0;
      stat_q <= apg_pkg::ST_RESET;
      nok_q <= '0;
      nrej_q <= '0;
      ax_q <= '0;
      ay_q <= '0;
      vx_q <= 1'b0;
      vy_q <= 1'b0;
      rej_q <= 1'b0;
      rd_q <= '0;
      wait_q <= 1'b1;
    end else begin
      ptr_q <= ptr_d;
      base_q <= base_d;
      tidx0_q <= tidx0_d;
      tidx1_q <= tidx1_d;
      stat_q <= stat_d;
      nok_q <= nok_d;
      nrej_q <= nrej_d;
      ax_q <= ax_d;
      ay_q <= ay_d;
      vx_q <= vx_d;
      vy_q <= vy_d;
      rej_q <= rej_d;
      rd_q <= rd_d;
      wait_q <= wait_d;
    end
  end

  assign avs_readdata = rd_q;
  assign avs_waitrequest = wait_q;
  assign addr_x = ax_q;
  assign addr_y = ay_q;
  assign addr_x_valid = vx_q;
  assign addr_y_valid = vy_q;
  assign op_reject = rej_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_plain_x;
    op_valid && !op_pair && mode_x == apg_pkg::OM_PLAIN && !stat_q[sel_ptr_x] && !bus_wr;
  endsequence
  sequence s_postinc_x;
    op_valid && mode_x == apg_pkg::OM_POST_INC && !wide_x && ok_y
      && !stat_q[sel_ptr_x] && !(op_pair && uy_wr && sel_ptr_y == sel_ptr_x);
  endsequence

  plain_keeps_a: assert property (s_plain_x |=> addr_x_valid && addr_x == $past(ptr_q[sel_ptr_x])
    && ptr_q[$past(sel_ptr_x)] == $past(ptr_q[sel_ptr_x]))
    else $error("plain form changed pointer or address"); // see (R8)
  postinc_step_a: assert property (s_postinc_x |=> addr_x == $past(ptr_q[sel_ptr_x])
    && ptr_q[$past(sel_ptr_x)] == 23'($past(ptr_q[sel_ptr_x]) + 23'h000001))
    else $error("post increment step wrong"); // see (R6)
  k16_pair_a: assert property (op_valid && op_pair && (mode_x == apg_pkg::OM_BASE_K16
    || mode_x == apg_pkg::OM_PRE_ADD_K16) |=> op_reject && !addr_x_valid)
    else $error("long constant accepted in parallel"); // see (R4)
  dual_two_a: assert property (accept && op_pair |=> addr_x_valid && addr_y_valid
    && addr_y == $past(uy_addr))
    else $error("dual issue missing second address"); // see (R10)
  single_one_a: assert property (op_valid && !op_pair |=> !addr_y_valid)
    else $error("second address on single request"); // see (R12)
  base_circ_a: assert property (accept && stat_q[sel_ptr_x] && mode_x == apg_pkg::OM_PLAIN
    |=> addr_x == {$past(ptr_q[sel_ptr_x][22:16]),
    16'($past(ptr_q[sel_ptr_x][15:0]) + $past(base_q[sel_ptr_x[2:1]]))})
    else $error("circular base not added"); // see (R18)
  brev_circ_a: assert property (accept && !bus_wr && stat_q[sel_ptr_x] && mode_x inside
    {apg_pkg::OM_BREV_ADD, apg_pkg::OM_BREV_SUB} ##1 !(vy_q && $past(uy_wr))
    |-> ptr_q[$past(sel_ptr_x)] == $past(ptr_q[sel_ptr_x]))
    else $error("circular bit reverse moved pointer"); // see (R2)
  k3_ctl_a: assert property (op_valid && !op_pair && mode_x == apg_pkg::OM_BASE_K3
    |=> op_reject == !$past(pms))
    else $error("short offset legality wrong"); // see (R9)
  reject_count_a: assert property (op_reject |-> nrej_q == 16'($past(nrej_q) + 16'h0001))
    else $error("reject count not advanced"); // see (R13)
  bus_ack_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
    ##1 avs_waitrequest)
    else $error("bus answer not after one wait"); // see (R22)
endmodule : apg_top

// ===== apg_top_bench.sv
// Purpose: Self-checking bench for the pointer address generator
// Assumes: Operands come from a fixed-seed shift register; integer reference model
// Notes: Expected results queue per request and are compared at falling edges
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module apg_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] DUAL_SET = 16'h06e7; // Forms legal for two operands
  localparam logic [15:0] CTRL_BAD = 16'h1f18; // Forms missing from the control list
  logic mclk, rst; // Clock and reset
  logic [7:0] avs_address; // Bus address
  logic avs_read, avs_write, avs_waitrequest; // Bus strobes
  logic [31:0] avs_writedata, avs_readdata; // Bus data
  logic op_valid, op_pair, wide_x, wide_y, addr_x_valid, addr_y_valid, op_reject; // Flags
  logic [2:0] sel_ptr_x, sel_ptr_y, short_offset_const; // Pointers and short offset
  apg_pkg::apg_mode_e mode_x, mode_y; // Forms
  logic [15:0] long_offset_const; // Long offset
  logic [22:0] addr_x, addr_y; // Issued addresses
  int n_errors = 0, n_tests = 0, cyc = 0; // Counters
  int regs [16]; // Reference register file
  int acc_n = 0, rej_n = 0; // Reference event counts
  int qk [$], qx [$], qy [$]; // Pending expectations
  logic [31:0] lfsr = 32'h00000036; // Random source state
  apg_top i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .op_valid(op_valid),
    .op_pair(op_pair), .sel_ptr_x(sel_ptr_x), .mode_x(mode_x), .wide_x(wide_x),
    .sel_ptr_y(sel_ptr_y), .mode_y(mode_y), .wide_y(wide_y),
    .long_offset_const(long_offset_const), .short_offset_const(short_offset_const),
    .addr_x(addr_x), .addr_y(addr_y), .addr_x_valid(addr_x_valid),
    .addr_y_valid(addr_y_valid), .op_reject(op_reject));
  apg_dec_model i_dec (.mclk(mclk), .op_valid(op_valid), .op_pair(op_pair),
    .sel_ptr_x(sel_ptr_x), .mode_x(mode_x), .wide_x(wide_x), .sel_ptr_y(sel_ptr_y),
    .mode_y(mode_y), .wide_y(wide_y), .long_offset_const(long_offset_const),
    .short_offset_const(short_offset_const));
  // Clock generator
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Next random word
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  // Reverse the low 16 bits
  function automatic int rev16(int v);
    int r;
    r = 0;
    for (int b = 0; b < 16; b++) r[15 - b] = v[b];
    return r;
  endfunction : rev16
  // Implemented bits of each register
  function automatic int msk(int j);
    return j < 8 ? 32'h007fffff : j < 14 ? 32'h0000ffff : 32'h000003ff;
  endfunction : msk
  // Address and new pointer of one operand
  function automatic void calc(int n, apg_pkg::apg_mode_e m, bit w, int k16, int k3,
      output int a, output int np);
    int p, st, ix, ti, d, ao, b, e;
    bit c, pre;
    p = regs[n];
    c = regs[14][n];
    b = regs[10 + n / 2];
    st = w ? 2 : 1;
    ix = regs[14][9] ? $signed(regs[0][15:0]) : $signed(regs[8][15:0]);
    ti = $signed(regs[9][15:0]);
    {d, ao, pre} = '0;
    case (m)
      apg_pkg::OM_POST_INC: d = st;
      apg_pkg::OM_POST_DEC: d = -st;
      apg_pkg::OM_PRE_INC: {d, pre} = {st, 1'b1};
      apg_pkg::OM_PRE_DEC: {d, pre} = {-st, 1'b1};
      apg_pkg::OM_POST_ADD_IDX: d = ix;
      apg_pkg::OM_POST_SUB_IDX: d = -ix;
      apg_pkg::OM_BASE_IDX: ao = ix;
      apg_pkg::OM_BASE_T1: ao = ti;
      apg_pkg::OM_POST_ADD_T1: d = ti;
      apg_pkg::OM_POST_SUB_T1: d = -ti;
      apg_pkg::OM_BASE_K16: ao = k16;
      apg_pkg::OM_PRE_ADD_K16: {d, pre} = {k16, 1'b1};
      apg_pkg::OM_BASE_K3: ao = k3;
      default: d = 0;
    endcase
    np = c ? {p[22:16], 16'(p + d)} : (p + d) & 32'h007fffff;
    if (m inside {apg_pkg::OM_BREV_ADD, apg_pkg::OM_BREV_SUB}) begin
      d = m == apg_pkg::OM_BREV_ADD ? rev16(ix) : -rev16(ix);
      np = c ? p : {p[22:16], 16'(rev16(rev16(p) + d))};
    end
    e = pre ? np : p;
    a = c ? {e[22:16], 16'(e + ao + b)} : (e + ao) & 32'h007fffff;
  endfunction : calc
  // Whether a form is refused for this request kind
  function automatic bit refused(bit pr, apg_pkg::apg_mode_e m);
    if (pr) return !DUAL_SET[m];
    if (regs[14][8]) return CTRL_BAD[m];
    return m == apg_pkg::OM_BASE_K3;
  endfunction : refused
  // One bus access, held until waitrequest is seen low
  task automatic bus(bit wr, int a, logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= 8'(a);
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Write and mirror into the reference
  task automatic wreg(int a, logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a % 4 == 0 && a < 60) regs[a / 4] = d & msk(a / 4);
  endtask : wreg
  // Read and compare with the reference
  task automatic rreg(int a);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    `CHK("register", q, a >= 64 ? 0 : a == 60 ? {rej_n[15:0], acc_n[15:0]} : regs[a / 4])
  endtask : rreg
  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // Compare each response with the oldest expectation
  always @(negedge mclk) begin
    int k, x, y;
    if (addr_x_valid === 1'b1 || op_reject === 1'b1) begin
      {k, x, y} = {32'hffffffff, 64'h0};
      if (qk.size() > 0) {k, x, y} = {qk.pop_front(), qx.pop_front(), qy.pop_front()};
      `CHK("op_reject", op_reject, k == 0)
      `CHK("addr_x_valid", addr_x_valid, k > 0)
      `CHK("addr_y_valid", addr_y_valid, k == 2)
      if (k > 0) `CHK("addr_x", addr_x, x)
      if (k == 2) `CHK("addr_y", addr_y, y)
    end
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  // Main sequence
  initial begin
    logic [31:0] r, s;
    int px, py, ax, ay, nx, ny, k16;
    bit pr;
    apg_pkg::apg_mode_e mx, my;
    {rst, avs_address, avs_read, avs_write, avs_writedata} = {1'b1, 42'h0};
    regs = '{default: 0};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int a = 0; a < 68; a += 4) rreg(a);
    wreg(1, 32'hffffffff);
    wreg(60, 32'hffffffff);
    rreg(0);
    rreg(60);
    for (int blk = 0; blk < 48; blk++) begin
      for (int j = 0; j < 15; j++) wreg(j * 4, rnd());
      for (int i = 0; i < 24; i++) begin
        r = rnd();
        s = rnd();
        pr = r[2];
        mx = apg_pkg::apg_mode_e'(r[7:4]);
        my = apg_pkg::apg_mode_e'(r[11:8]);
        px = r[14:12];
        py = r[17:15];
        if (pr && py == px) py = (px + 1) % 8;
        k16 = $signed(s[15:0]);
        if (r[1:0] != 2'h0) begin
          if (refused(pr, mx) || (pr && refused(pr, my))) begin
            qk.push_back(0);
            qx.push_back(0);
            qy.push_back(0);
            rej_n++;
          end else begin
            calc(px, mx, r[18], k16, s[18:16] % 7 + 1, ax, nx);
            if (pr) calc(py, my, r[19], k16, s[18:16] % 7 + 1, ay, ny);
            regs[px] = nx;
            if (pr) regs[py] = ny;
            qk.push_back(pr ? 2 : 1);
            qx.push_back(ax);
            qy.push_back(ay);
            acc_n++;
          end
        end
        i_dec.send(r[1:0] != 2'h0, pr, px[2:0], mx, r[18], py[2:0], my, r[19], s[15:0],
          3'(s[18:16] % 7 + 1));
      end
      i_dec.send(1'b0, 1'b0, 3'h0, apg_pkg::OM_PLAIN, 1'b0, 3'h1, apg_pkg::OM_PLAIN, 1'b0,
        16'h0000, 3'h1);
      for (int j = 0; j < 16; j++) rreg(j * 4);
    end
    `CHK("pending", qk.size(), 0)
    close_out();
  end
endmodule : apg_top_bench

// ===== apg_unit.sv
// Purpose: One operand address and pointer update computation
// Assumes: Purely combinational; caller supplies the chosen index
// Notes: Circular wrap is at the 64K page boundary; no buffer size is applied
module apg_unit (
  input wire logic [22:0] ptr, // Current extended pointer
  input wire apg_pkg::apg_mode_e mode, // Operand form
  input wire logic wide, // 32-bit or bit-pair access
  input wire logic [15:0] idx, // Selected index (zero pointer or temp zero)
  input wire logic [15:0] tone, // temp_index_one value
  input wire logic [15:0] kconst, // long_offset_const
  input wire logic [2:0] kshort, // short_offset_const
  input wire logic circ, // Pointer is circular
  input wire logic [15:0] base, // Matching circ_buffer_base
  output logic [22:0] addr, // Issued address
  output logic [22:0] ptr_new, // Updated pointer
  output logic ptr_wr // Pointer is written back
);
  // Reverse the bit order of a 16-bit word
  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction : rev16

  logic [22:0] off; // Signed offset, extended
  logic upd; // Form modifies the pointer
  logic pre; // Address uses updated pointer
  logic bform; // Address is pointer plus offset, pointer kept
  logic brev; // Reverse carry form
  logic bsub; // Reverse carry subtract
  logic [22:0] sum; // Pointer plus offset modulo 8M
  logic [22:0] lin_new; // Linear update
  logic [22:0] cir_new; // Circular update keeps the page
  logic [15:0] rsum; // Reverse carry result
  logic [22:0] eff; // Pointer value before base add
  logic [22:0] step; // Post or pre step

  // Decode operand form into offset and flags
  always_comb begin
    step = wide ? apg_pkg::STEP_WIDE : apg_pkg::STEP_NARROW; // see (R6) see (R15)
    off = '0;
    upd = 1'b0;
    pre = 1'b0;
    bform = 1'b0;
    brev = 1'b0;
    bsub = 1'b0;
    unique case (mode)
      apg_pkg::OM_PLAIN: off = '0;
      apg_pkg::OM_POST_INC: begin off = step; upd = 1'b1; end // see (R6)
      apg_pkg::OM_POST_DEC: begin off = 23'(-step); upd = 1'b1; end // see (R6)
      apg_pkg::OM_PRE_INC: begin off = step; upd = 1'b1; pre = 1'b1; end
      apg_pkg::OM_PRE_DEC: begin off = 23'(-step); upd = 1'b1; pre = 1'b1; end
      apg_pkg::OM_POST_ADD_IDX: begin off = {{7{idx[15]}}, idx}; upd = 1'b1; end // see (R7)
      apg_pkg::OM_POST_SUB_IDX: begin off = 23'(-{{7{idx[15]}}, idx}); upd = 1'b1; end
      apg_pkg::OM_BASE_IDX: begin off = {{7{idx[15]}}, idx}; bform = 1'b1; end // see (R8)
      apg_pkg::OM_BASE_T1: begin off = {{7{tone[15]}}, tone}; bform = 1'b1; end
      apg_pkg::OM_POST_ADD_T1: begin off = {{7{tone[15]}}, tone}; upd = 1'b1; end // see (R14)
      apg_pkg::OM_POST_SUB_T1: begin off = 23'(-{{7{tone[15]}}, tone}); upd = 1'b1; end
      apg_pkg::OM_BREV_ADD: begin brev = 1'b1; upd = 1'b1; end
      apg_pkg::OM_BREV_SUB: begin brev = 1'b1; bsub = 1'b1; upd = 1'b1; end // see (R1)
      apg_pkg::OM_BASE_K16: begin off = {{7{kconst[15]}}, kconst}; bform = 1'b1; end // see (R3)
      apg_pkg::OM_PRE_ADD_K16: begin // see (R5)
        off = {{7{kconst[15]}}, kconst};
        upd = 1'b1;
        pre = 1'b1;
      end
      apg_pkg::OM_BASE_K3: begin off = {20'h00000, kshort}; bform = 1'b1; end // see (R9)
    endcase
  end

  // Arithmetic and address forming
  always_comb begin
    sum = ptr + off; // Wraps modulo 8M, page follows carries; see (R17)
    lin_new = sum;
    cir_new = {ptr[22:16], sum[15:0]}; // see (R21)
    // Carry runs from high bit toward low bit
    rsum = bsub ? rev16(rev16(ptr[15:0]) - rev16(idx))
                : rev16(rev16(ptr[15:0]) + rev16(idx)); // see (R1)
    if (brev) begin
      ptr_new = {ptr[22:16], rsum};
    end else if (circ) begin
      ptr_new = cir_new;
    end else begin
      ptr_new = lin_new;
    end
    ptr_wr = upd && !(brev && circ); // Circular bit-reverse pointer kept; see (R2)
    if (bform) begin
      eff = circ ? cir_new : lin_new;
    end else if (pre) begin
      eff = ptr_new;
    end else begin
      eff = ptr;
    end
    // Base add only for circular pointers; see (R18) see (R2)
    addr = circ ? {eff[22:16], 16'(eff[15:0] + base)} : eff; // see (R20)
  end
endmodule : apg_unit
